/* File: core/fpsc_pkg.sv */
package fpsc_pkg;

    // bus geometry
    localparam int unsigned WB_DW      = 32;
    localparam int unsigned WB_SW      = 4;
    localparam int unsigned REG_W      = 16;

    // register byte offsets
    localparam logic [7:0] ADR_STATUS  = 8'h00;
    localparam logic [7:0] ADR_DISC    = 8'h04;
    localparam logic [7:0] ADR_FCAR    = 8'h08;
    localparam logic [7:0] ADR_RXERR   = 8'h0C;
    localparam logic [7:0] ADR_ADV     = 8'h10;

    // status word field positions
    localparam int unsigned ST_LATCH_N = 6;
    localparam int unsigned ST_CIM     = 6;
    localparam int unsigned ST_FAULT   = 7;
    localparam int unsigned ST_LINK    = 8;
    localparam int unsigned ST_LOCKED  = 9;
    localparam int unsigned ST_FIBRE   = 10;

    // counter default widths and the widest allowed counter
    localparam int unsigned DISC_W_DEF = 8;
    localparam int unsigned FCAR_W_DEF = 8;
    localparam int unsigned RXE_W_DEF  = 16;
    localparam int unsigned CNT_W_MAX  = 16;

    // advertise register layout
    localparam int unsigned ADV_SEL_W   = 5;
    localparam logic [4:0]  ADV_SEL_VAL = 5'h01;
    localparam int unsigned ADV_ABIL_LO = 5;
    localparam int unsigned ADV_ABIL_W  = 4;
    localparam int unsigned ADV_T4      = 9;
    localparam int unsigned ADV_PAUSE   = 10;
    localparam int unsigned ADV_RFAULT  = 13;
    localparam logic [3:0]  ADV_ABIL_DEF = 4'hF;
    localparam logic [15:0] REG_ZERO    = 16'h0000;

    // one-cycle event strobes; bit order matches status bits 5..0
    typedef struct packed {
        logic false_carrier;
        logic bad_stream_end_delimiter;
        logic invalid_code;
        logic tx_err_code;
        logic lock_lost;
        logic mlt3_code_err;
    } fpsc_evt_s;

    // live levels from the receive path
    typedef struct packed {
        logic cim_isolated;
        logic far_end_fault;
        logic link_good;
        logic descrambler_locked;
        logic speed_100;
        logic signal_detect_pair_p;
        logic signal_detect_pair_n;
    } fpsc_live_s;

    // receive frame framing
    typedef struct packed {
        logic frame_active;
        logic rx_err;
        logic collision;
    } fpsc_rxpkt_s;

    typedef enum logic [3:0] {
        PKT_IDLE  = 4'b0001,
        PKT_CLEAN = 4'b0010,
        PKT_ERR   = 4'b0100,
        PKT_COLL  = 4'b1000
    } fpsc_pkt_e;

endpackage

/* File: core/fpsc_regs.sv */
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps

// How it works
// - status bit 0 latches on an MLT3 coding violation, clears on status read
// - status bit 1 latches when descrambler loses lock, clears on status read
// - status bit 2 latches on a received transmit-error code symbol, read clears
// - status bit 3 latches on a packet with invalid code symbol, read clears
// - status bit 4 latches on a malformed stream end delimiter, read clears
// - status bit 5 latches on a false carrier event, read clears
// - status bit 6 live: monitor has isolated the port, only in 100 Mb/s
// - status bit 7 live: partner currently signals a far-end fault
// - status bit 8 live: 100 Mb/s link is good
// - status bit 9 live: descrambler is locked
// - status bit 10 is 1 with valid signal detect, 0 when both pins low
// - disconnect counter counts entries into link-unstable state, 8-bit field
// - disconnect counter clears on read and saturates at FFh
// - false-carrier counter counts each false carrier event, 8-bit field
// - false-carrier counter clears on read and saturates at FFh
// - receive-error counter counts errored non-collision packets once each
// - receive-error counter clears on read and saturates at FFFFh
// - writable advertise register sets capabilities offered to the partner
// - advertise bits 4:0 read-only selector 00001
// - advertise bits 5..8 read back last write, else ability default
module fpsc_regs #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned DISC_W = fpsc_pkg::DISC_W_DEF,
    parameter int unsigned FCAR_W = fpsc_pkg::FCAR_W_DEF,
    parameter int unsigned RXE_W  = fpsc_pkg::RXE_W_DEF,
    parameter logic [3:0]  ABIL_DEFAULT = fpsc_pkg::ADV_ABIL_DEF,
    parameter logic        T4_DEFAULT   = 1'b0
) (
    // clock and reset
    input  wire logic                       sys_clk_in,
    input  wire logic                       nrst_in,
    // wishbone slave
    input  wire logic                       wb_cyc_in,
    input  wire logic                       wb_stb_in,
    input  wire logic                       wb_we_in,
    input  wire logic [ADDR_W-1:0]          wb_adr_in,
    input  wire logic [fpsc_pkg::WB_SW-1:0] wb_sel_in,
    input  wire logic [fpsc_pkg::WB_DW-1:0] wb_dat_in,
    output logic      [fpsc_pkg::WB_DW-1:0] wb_dat_out,
    output logic                            wb_ack_out,
    // receive path
    input  wire fpsc_pkg::fpsc_evt_s        evt_in,
    input  wire fpsc_pkg::fpsc_live_s       live_in,
    input  wire fpsc_pkg::fpsc_rxpkt_s      rxpkt_in,
    // auto-negotiation
    output logic      [fpsc_pkg::REG_W-1:0] ability_offer_out
);
    import fpsc_pkg::*;

    // bits 7:2 select the register, so the address needs at least eight bits
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W too narrow for the register map");
    end
    if ($bits(fpsc_evt_s) != ST_LATCH_N) begin : g_bad_evt
        $error("event strobes do not match the latched flag count");
    end
    if (ST_FIBRE >= REG_W) begin : g_bad_status
        $error("status word too narrow for its fields");
    end
    if ($bits(fpsc_live_s) != 7) begin : g_bad_live
        $error("live level carrier has an unexpected width");
    end
    if (DISC_W < 1 || DISC_W > CNT_W_MAX) begin : g_bad_disc
        $error("DISC_W out of range");
    end
    if (FCAR_W < 1 || FCAR_W > CNT_W_MAX) begin : g_bad_fcar
        $error("FCAR_W out of range");
    end
    if (RXE_W < 1 || RXE_W > CNT_W_MAX) begin : g_bad_rxe
        $error("RXE_W out of range");
    end

    localparam logic [DISC_W-1:0] DISC_MAX = '1;
    localparam logic [FCAR_W-1:0] FCAR_MAX = '1;
    localparam logic [RXE_W-1:0]  RXE_MAX  = '1;
    localparam logic [DISC_W-1:0] DISC_ONE = 1;
    localparam logic [FCAR_W-1:0] FCAR_ONE = 1;
    localparam logic [RXE_W-1:0]  RXE_ONE  = 1;

    // bus decode
    logic                   bus_req;
    logic                   rd_req;
    logic                   wr_req;
    logic [7:0]             reg_adr;
    logic                   hit_status;
    logic                   hit_disc;
    logic                   hit_fcar;
    logic                   hit_rxerr;
    logic                   hit_adv;
    logic                   upper_zero;

    // state
    logic [ST_LATCH_N-1:0]  sticky;
    logic [ST_LATCH_N-1:0]  evt_vec;
    logic                   cim_prev;
    logic                   disc_evt;
    logic [DISC_W-1:0]      disc_cnt;
    logic [FCAR_W-1:0]      fcar_cnt;
    logic [RXE_W-1:0]       rxe_cnt;
    logic                   rxe_evt;
    fpsc_pkt_e              pkt_state;
    fpsc_pkt_e              next_pkt_state;
    logic [ADV_ABIL_W-1:0]  adv_abil;
    logic                   adv_t4;
    logic                   adv_pause;
    logic                   adv_rfault;

    // read path
    logic [REG_W-1:0]       status_word;
    logic [REG_W-1:0]       adv_word;
    logic [WB_DW-1:0]       next_rd_data;

    // a request is served once; ack drops the cycle after it was given
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign rd_req  = bus_req & ~wb_we_in;
    assign wr_req  = bus_req & wb_we_in;

    assign reg_adr = {wb_adr_in[7:2], 2'b00};

    if (ADDR_W > 8) begin : g_upper
        assign upper_zero = ~|wb_adr_in[ADDR_W-1:8];
    end else begin : g_no_upper
        assign upper_zero = 1'b1;
    end

    always_comb begin
        hit_status = 1'b0;
        hit_disc   = 1'b0;
        hit_fcar   = 1'b0;
        hit_rxerr  = 1'b0;
        hit_adv    = 1'b0;
        if (!upper_zero) begin
            hit_status = 1'b0;
        end else if (reg_adr == ADR_STATUS) begin
            hit_status = 1'b1;
        end else if (reg_adr == ADR_DISC) begin
            hit_disc = 1'b1;
        end else if (reg_adr == ADR_FCAR) begin
            hit_fcar = 1'b1;
        end else if (reg_adr == ADR_RXERR) begin
            hit_rxerr = 1'b1;
        end else if (reg_adr == ADR_ADV) begin
            hit_adv = 1'b1;
        end
    end

    // wishbone acknowledge, one cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req;
        end
    end

    // latched error flags; the set term wins over a clearing read
    assign evt_vec = evt_in;

    for (genvar i = 0; i < ST_LATCH_N; i++) begin : g_sticky
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                sticky[i] <= 1'b0;
            end else if (evt_vec[i]) begin
                sticky[i] <= 1'b1;
            end else if (rd_req && hit_status) begin
                sticky[i] <= 1'b0;
            end
        end
    end

    // status word: live bits sampled directly, the only state is the flags
    always_comb begin
        status_word = REG_ZERO;
        status_word[ST_LATCH_N-1:0] = sticky;
        status_word[ST_CIM] = live_in.cim_isolated & live_in.speed_100;
        status_word[ST_FAULT] = live_in.far_end_fault;
        status_word[ST_LINK] = live_in.link_good;
        status_word[ST_LOCKED] = live_in.descrambler_locked;
        // both pins low means copper mode; any other level counts as valid
        status_word[ST_FIBRE] = live_in.signal_detect_pair_p
                              | live_in.signal_detect_pair_n;
    end

    // disconnects: count the entry into the isolated state, not its length
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cim_prev <= 1'b0;
        end else begin
            cim_prev <= live_in.cim_isolated;
        end
    end

    assign disc_evt = live_in.cim_isolated & ~cim_prev;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            disc_cnt <= '0;
        end else if (rd_req && hit_disc) begin
            disc_cnt <= disc_evt ? DISC_ONE : '0;
        end else if (disc_evt && disc_cnt != DISC_MAX) begin
            disc_cnt <= disc_cnt + DISC_ONE;
        end
    end

    // false carrier events
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fcar_cnt <= '0;
        end else if (rd_req && hit_fcar) begin
            fcar_cnt <= evt_in.false_carrier ? FCAR_ONE : '0;
        end else if (evt_in.false_carrier && fcar_cnt != FCAR_MAX) begin
            fcar_cnt <= fcar_cnt + FCAR_ONE;
        end
    end

    // packet tracker: one count per errored packet, collisions excluded
    always_comb begin
        next_pkt_state = pkt_state;
        rxe_evt = 1'b0;
        case (pkt_state)
            PKT_IDLE: begin
                if (rxpkt_in.frame_active) begin
                    if (rxpkt_in.collision) begin
                        next_pkt_state = PKT_COLL;
                    end else if (rxpkt_in.rx_err) begin
                        next_pkt_state = PKT_ERR;
                    end else begin
                        next_pkt_state = PKT_CLEAN;
                    end
                end
            end
            PKT_CLEAN: begin
                if (!rxpkt_in.frame_active) begin
                    next_pkt_state = PKT_IDLE;
                end else if (rxpkt_in.collision) begin
                    next_pkt_state = PKT_COLL;
                end else if (rxpkt_in.rx_err) begin
                    next_pkt_state = PKT_ERR;
                end
            end
            PKT_ERR: begin
                if (!rxpkt_in.frame_active) begin
                    next_pkt_state = PKT_IDLE;
                    rxe_evt = 1'b1;
                end else if (rxpkt_in.collision) begin
                    next_pkt_state = PKT_COLL;
                end
            end
            PKT_COLL: begin
                if (!rxpkt_in.frame_active) begin
                    next_pkt_state = PKT_IDLE;
                end
            end
            default: begin
                next_pkt_state = PKT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pkt_state <= PKT_IDLE;
        end else begin
            pkt_state <= next_pkt_state;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rxe_cnt <= '0;
        end else if (rd_req && hit_rxerr) begin
            rxe_cnt <= rxe_evt ? RXE_ONE : '0;
        end else if (rxe_evt && rxe_cnt != RXE_MAX) begin
            rxe_cnt <= rxe_cnt + RXE_ONE;
        end
    end

    // advertise register; byte lane 0 carries bits 7:0, lane 1 bits 15:8
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adv_abil <= ABIL_DEFAULT;
        end else if (wr_req && hit_adv) begin
            if (wb_sel_in[0]) begin
                adv_abil[2:0] <= wb_dat_in[ADV_ABIL_LO+2:ADV_ABIL_LO];
            end
            if (wb_sel_in[1]) begin
                adv_abil[3] <= wb_dat_in[ADV_ABIL_LO+3];
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adv_t4 <= T4_DEFAULT;
        end else if (wr_req && hit_adv && wb_sel_in[1]) begin
            adv_t4 <= wb_dat_in[ADV_T4];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adv_pause <= 1'b0;
        end else if (wr_req && hit_adv && wb_sel_in[1]) begin
            adv_pause <= wb_dat_in[ADV_PAUSE];
        end
    end

    // remote fault is only ever cleared by software or by chip reset
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adv_rfault <= 1'b0;
        end else if (wr_req && hit_adv && wb_sel_in[1]) begin
            adv_rfault <= wb_dat_in[ADV_RFAULT];
        end
    end

    // next page is never offered, so bit 15 stays zero whatever is written
    always_comb begin
        adv_word = REG_ZERO;
        adv_word[ADV_SEL_W-1:0] = ADV_SEL_VAL;
        adv_word[ADV_ABIL_LO+ADV_ABIL_W-1:ADV_ABIL_LO] = adv_abil;
        adv_word[ADV_T4] = adv_t4;
        adv_word[ADV_PAUSE] = adv_pause;
        adv_word[ADV_RFAULT] = adv_rfault;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ability_offer_out <= REG_ZERO;
        end else begin
            ability_offer_out <= adv_word;
        end
    end

    // read mux; an unmapped address answers with zero data
    always_comb begin
        next_rd_data = '0;
        if (hit_status) begin
            next_rd_data[REG_W-1:0] = status_word;
        end else if (hit_disc) begin
            next_rd_data[DISC_W-1:0] = disc_cnt;
        end else if (hit_fcar) begin
            next_rd_data[FCAR_W-1:0] = fcar_cnt;
        end else if (hit_rxerr) begin
            next_rd_data[RXE_W-1:0] = rxe_cnt;
        end else if (hit_adv) begin
            next_rd_data[REG_W-1:0] = adv_word;
        end
    end

    // data is captured at the same edge that clears, so the old value is read
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wb_dat_out <= '0;
        end else if (rd_req) begin
            wb_dat_out <= next_rd_data;
        end
    end

endmodule

/* File: sim/fpsc_properties.sv */
`timescale 1ns/100ps
module fpsc_properties
    import fpsc_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic                       sys_clk_in,
    input wire logic                       nrst_in,
    // wishbone
    input wire logic                       wb_cyc_in,
    input wire logic                       wb_stb_in,
    input wire logic                       wb_we_in,
    input wire logic [ADDR_W-1:0]          wb_adr_in,
    input wire logic [fpsc_pkg::WB_DW-1:0] wb_dat_out,
    input wire logic                       wb_ack_out,
    // receive path and offer
    input wire fpsc_pkg::fpsc_evt_s        evt_in,
    input wire fpsc_pkg::fpsc_live_s       live_in,
    input wire logic [fpsc_pkg::REG_W-1:0] ability_offer_out
);
    logic tk_st;
    logic tk_nar;
    logic st_ack;
    // remember what was taken, so the answer edge knows which register it carries
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tk_st <= 1'b0;
            tk_nar <= 1'b0;
        end else if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
            tk_st <= !wb_we_in && wb_adr_in[7:0] == ADR_STATUS;
            tk_nar <= !wb_we_in && (wb_adr_in[7:0] == ADR_DISC || wb_adr_in[7:0] == ADR_FCAR);
        end
    end
    assign st_ack = wb_ack_out && tk_st;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    AST_ACK_NEXT: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not acked");
    AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    AST_SEL: assert property ($past(nrst_in) |-> ability_offer_out[4:0] == ADV_SEL_VAL)
        else $error("selector field wrong");
    AST_FLAGS: assert property (st_ack |-> ($past(evt_in, 2) & ~wb_dat_out[5:0]) == 6'h00)
        else $error("event flag lost");
    AST_CIM: assert property (st_ack |-> wb_dat_out[6] == $past(live_in.cim_isolated && live_in.speed_100))
        else $error("isolation bit wrong");
    AST_LIVE: assert property (st_ack |-> wb_dat_out[9:7] == $past({live_in.descrambler_locked, live_in.link_good, live_in.far_end_fault}))
        else $error("live status bits wrong");
    AST_FIBRE: assert property (st_ack |-> wb_dat_out[10] == $past(live_in.signal_detect_pair_p || live_in.signal_detect_pair_n))
        else $error("fibre mode bit wrong");
    AST_NARROW: assert property (wb_ack_out && tk_nar |-> wb_dat_out[31:8] == 24'h000000)
        else $error("narrow counter upper bits set");
    AST_ST_UPPER: assert property (st_ack |-> wb_dat_out[31:11] == 21'h000000)
        else $error("status upper bits set");
    cover property (st_ack && wb_dat_out[5:0] != 6'h00);
    cover property (wb_ack_out && tk_nar && wb_dat_out[7:0] == 8'hFF);
    cover property (wb_cyc_in && wb_stb_in && wb_we_in);
endmodule

bind fpsc_regs fpsc_properties #(.ADDR_W(ADDR_W)) u_prop (.sys_clk_in, .nrst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .evt_in, .live_in,
    .ability_offer_out);

/* File: sim/fpsc_rx_model.sv */
`timescale 1ns/100ps
module fpsc_rx_model
    import fpsc_pkg::*;
(
    // clock
    input  wire logic            sys_clk_in,
    // receive path
    output fpsc_pkg::fpsc_evt_s   evt_out,
    output fpsc_pkg::fpsc_live_s  live_out,
    output fpsc_pkg::fpsc_rxpkt_s rxpkt_out
);
    initial begin
        evt_out = '0;
        live_out = '0;
        rxpkt_out = '0;
    end
    task automatic pulse(input fpsc_evt_s e);
        @(posedge sys_clk_in);
        evt_out <= e;
        @(posedge sys_clk_in);
        evt_out <= '0;
    endtask
    task automatic set_live(input fpsc_live_s v);
        @(posedge sys_clk_in);
        live_out <= v;
    endtask
    // errors land in the first cycles, so a first-cycle error is exercised
    task automatic frame(input int errs, input logic coll);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_in);
            rxpkt_out <= '{frame_active: 1'b1, rx_err: i < errs, collision: coll};
        end
        @(posedge sys_clk_in);
        rxpkt_out <= '0;
        @(posedge sys_clk_in);
    endtask
endmodule

/* File: sim/test_fast_phy_status_counters.sv */
`timescale 1ns/100ps
module test_fast_phy_status_counters;
    import fpsc_pkg::*;
    // short receive-error counter keeps saturation reachable in a short run
    localparam int unsigned RXE_W   = 4;
    localparam logic [31:0] RXE_MAX = 32'((1 << RXE_W) - 1);
    typedef struct packed {logic [5:0] e; logic [6:0] v; logic [15:0] x;} fpsc_row_s;
    fpsc_row_s   rows [9] = '{'{6'h01, 7'h00, 16'h0001}, '{6'h02, 7'h44, 16'h0042},
        '{6'h04, 7'h40, 16'h0004}, '{6'h08, 7'h20, 16'h0088}, '{6'h10, 7'h10, 16'h0110},
        '{6'h20, 7'h08, 16'h0220}, '{6'h00, 7'h02, 16'h0400}, '{6'h00, 7'h01, 16'h0400},
        '{6'h3F, 7'h03, 16'h043F}};
    logic [7:0]  regs [4] = '{ADR_STATUS, ADR_DISC, ADR_FCAR, ADR_RXERR};
    logic        sys_clk_in, nrst_in, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] offer;
    fpsc_evt_s   evt;
    fpsc_live_s  live;
    fpsc_rxpkt_s rxpkt;
    int          mismatches = 0, n_compared = 0, cycles = 0;

    fpsc_regs #(.RXE_W(RXE_W)) uut (.sys_clk_in, .nrst_in, .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .evt_in(evt), .live_in(live), .rxpkt_in(rxpkt),
        .ability_offer_out(offer));
    fpsc_rx_model u_rx (.sys_clk_in, .evt_out(evt), .live_out(live), .rxpkt_out(rxpkt));

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic test_done;
        $display("counts: %0d mismatches, %0d compared", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // ack is sampled at the rising edge that also ends the request
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: no ack", $time);
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h00000000, 4'hF);
        chk(q, e);
    endtask

    initial begin
        {nrst_in, cyc, stb, we, adr} = '0;
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        foreach (rows[i]) begin
            u_rx.set_live(rows[i].v);
            u_rx.pulse(rows[i].e);
            rd(ADR_STATUS, {16'h0000, rows[i].x});
            rd(ADR_STATUS, {16'h0000, rows[i].x & 16'hFFC0});
        end
        u_rx.set_live(7'h00);
        rd(ADR_DISC, 32'h00000001);
        rd(ADR_FCAR, 32'h00000002);
        wb(1'b1, ADR_DISC, 32'hFFFFFFFF, 4'hF);
        wb(1'b1, ADR_STATUS, 32'hFFFFFFFF, 4'hF);
        rd(ADR_DISC, 32'h00000000);
        rd(ADR_STATUS, 32'h00000000);
        rd(8'h14, 32'h00000000);
        repeat (300) begin
            u_rx.set_live(7'h44);
            u_rx.set_live(7'h00);
            u_rx.pulse(6'h20);
        end
        rd(ADR_DISC, 32'h000000FF);
        rd(ADR_DISC, 32'h00000000);
        rd(ADR_FCAR, 32'h000000FF);
        rd(ADR_FCAR, 32'h00000000);
        rd(ADR_STATUS, 32'h00000020);
        u_rx.frame(1, 1'b0);
        u_rx.frame(3, 1'b0);
        u_rx.frame(2, 1'b1);
        u_rx.frame(0, 1'b0);
        rd(ADR_RXERR, 32'h00000002);
        repeat (20) u_rx.frame(1, 1'b0);
        rd(ADR_RXERR, RXE_MAX);
        rd(ADR_RXERR, 32'h00000000);
        fork
            wb(1'b0, ADR_FCAR, 32'h00000000, 4'hF);
            u_rx.pulse(6'h20);
        join
        rd(ADR_FCAR, 32'h00000001);
        rd(ADR_STATUS, 32'h00000020);
        fork
            wb(1'b0, ADR_STATUS, 32'h00000000, 4'hF);
            u_rx.pulse(6'h01);
        join
        rd(ADR_STATUS, 32'h00000001);
        rd(ADR_ADV, 32'h000001E1);
        chk({16'h0000, offer}, 32'h000001E1);
        wb(1'b1, ADR_ADV, 32'hFFFFFFFF, 4'hF);
        rd(ADR_ADV, 32'h000027E1);
        wb(1'b1, ADR_ADV, 32'h00000000, 4'h1);
        rd(ADR_ADV, 32'h00002701);
        chk({16'h0000, offer}, 32'h00002701);
        u_rx.pulse(6'h3F);
        u_rx.frame(1, 1'b0);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        foreach (regs[i]) rd(regs[i], 32'h00000000);
        rd(ADR_ADV, 32'h000001E1);
        test_done;
    end
endmodule
